// File: design/col_debounce.sv
// per-bit contact debouncer on the millisecond tick
`timescale 1ns/1ps
`include "col_defines.svh"

module col_debounce #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] stable
);

    // a level is taken once it held for the whole window; both edges delayed alike
    for (genvar b = 0; b < W; b++) begin : g_bit
        logic [2:0] cnt;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt <= 3'h0;
                stable[b] <= 1'b0;
            end else if (raw[b] == stable[b]) begin
                cnt <= 3'h0;
            end else if (tick) begin
                if (cnt == 3'(`COL_DEBOUNCE_TICKS - 1)) begin
                    stable[b] <= raw[b];
                    cnt <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end

endmodule : col_debounce

// File: design/col_defines.svh
// timing counts, register offsets, field positions and reset values of the outlet supervisor
`ifndef COL_DEFINES_SVH
`define COL_DEFINES_SVH

// clock and millisecond timebase
`define COL_CLK_PERIOD_NS 4
`define COL_TICK_NS 1000000
`define COL_MS_CYCLES (`COL_TICK_NS / `COL_CLK_PERIOD_NS)

// times in milliseconds; one tick is one millisecond
`define COL_DEBOUNCE_MS 5
`define COL_PULSE_MIN_MS 30
`define COL_PULSE_MAX_MS 200
`define COL_FLASH_MS 500
`define COL_BACKUP_WAIT_MS 260000
`define COL_DEBOUNCE_TICKS (`COL_DEBOUNCE_MS)
`define COL_PULSE_MIN_TICKS (`COL_PULSE_MIN_MS)
`define COL_PULSE_MAX_TICKS (`COL_PULSE_MAX_MS)
`define COL_FLASH_TICKS (`COL_FLASH_MS)
`define COL_BACKUP_WAIT_TICKS (`COL_BACKUP_WAIT_MS)

// energy conversion: watt-hours in one kilowatt-hour
`define COL_WH_PER_KWH 17'h003E8

// register byte offsets
`define COL_ADR_CFG 8'h00
`define COL_ADR_PPK 8'h04
`define COL_ADR_CMD 8'h08
`define COL_ADR_STATUS_A 8'h0C
`define COL_ADR_STATUS_B 8'h10
`define COL_ADR_ENERGY_A 8'h14
`define COL_ADR_ENERGY_B 8'h18

// configuration fields; outlet b magnet bit sits one bit above outlet a, the lock timeout field is shared
`define COL_CFG_MAGNET 0
`define COL_CFG_TMO_LSB 16
`define COL_CFG_RST 32'h0BB80000
`define COL_PPK_RST 16'h03E8

// command fields, write-one pulses; outlet b sits one bit above outlet a
`define COL_CMD_START 0
`define COL_CMD_STOP 2
`define COL_CMD_OPT 4
`define COL_CMD_CLR 8

`endif

// File: design/col_pkg.sv
// types shared by the outlet supervisor files
package col_pkg;

    // per-outlet inputs from station hardware and cable/pilot logic
    typedef struct packed {
        logic lock_sw;
        logic contactor_fb;
        logic rcd_trip;
        logic meter;
        logic start_key_n;
        logic stop_key_n;
        logic opt_key_n;
        logic cable_ok;
        logic vehicle_ready;
        logic cable_bad;
    } col_in_t;

    // per-outlet outputs to lock driver, contactor and panel
    typedef struct packed {
        logic lock_pos;
        logic lock_neg;
        logic contactor_on;
        logic fault_lamp;
        logic ready_lamp;
        logic optimised_lamp;
    } col_out_t;

    typedef enum logic [2:0] {
        COL_IDLE,
        COL_ARMED,
        COL_LOCKING,
        COL_CHARGING,
        COL_STOPPING,
        COL_UNLOCKING
    } col_state_t;

endpackage : col_pkg

// File: design/col_top.sv
// two-outlet lock, feedback, meter and panel supervisor with a classic wishbone slave
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "col_defines.svh"

module col_top #(
    parameter int unsigned MS_CYCLES = `COL_MS_CYCLES,
    parameter int unsigned BACKUP_WAIT_MS = `COL_BACKUP_WAIT_TICKS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire col_pkg::col_in_t outlet_a_in,
    input wire col_pkg::col_in_t outlet_b_in,
    input wire logic mains_ok,
    input wire logic backup_present,
    input wire logic backup_energy_ok,
    output col_pkg::col_out_t outlet_a_out,
    output col_pkg::col_out_t outlet_b_out
);

    logic [17:0] ms_cnt;
    logic ms_tick;
    logic [9:0] flash_cnt;
    logic flash;
    logic [31:0] cfg;
    logic [15:0] ppk;
    logic wb_req;
    logic wb_wr;
    logic [31:0] wmask;
    logic [31:0] cmd;
    logic [31:0] rd_mux;
    logic [2:0] sh_raw;
    logic [2:0] sh_db;
    logic mains_up;
    logic backup_fitted;
    logic energy_ok;
    logic drive_ok;
    col_pkg::col_in_t raw_in [2];

    // millisecond timebase; the long divide is a parameter so a bench can shorten it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ms_cnt <= 18'h00000;
            ms_tick <= 1'b0;
        end else if (ms_cnt == 18'(MS_CYCLES - 1)) begin
            ms_cnt <= 18'h00000;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 18'h00001;
            ms_tick <= 1'b0;
        end
    end

    // shared flash rhythm keeps both ready lamps in step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_cnt <= 10'h000;
            flash <= 1'b0;
        end else if (ms_tick) begin
            if (flash_cnt == 10'(`COL_FLASH_TICKS - 1)) begin
                flash_cnt <= 10'h000;
                flash <= ~flash;
            end else begin
                flash_cnt <= flash_cnt + 10'h001;
            end
        end
    end

    // box-wide contacts: mains, backup detect, stored energy
    assign sh_raw = {mains_ok, backup_present, backup_energy_ok};

    col_debounce #(
        .W(3)
    ) u_db_shared (
        .clk(clk),
        .arst_n(arst_n),
        .tick(ms_tick),
        .raw(sh_raw),
        .stable(sh_db)
    );

    assign mains_up = sh_db[2];
    assign backup_fitted = sh_db[1];
    assign energy_ok = sh_db[0];
    // without backup board the external supply always moves the pins
    assign drive_ok = ~backup_fitted | energy_ok;

    // wishbone decode; ack one cycle after the request, for one cycle
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cmd = (wb_wr && wb_adr_i == `COL_ADR_CMD) ? (wb_dat_i & wmask) : 32'h00000000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // configuration: lock type per outlet, lock timeout, meter resolution
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= `COL_CFG_RST;
            ppk <= `COL_PPK_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == `COL_ADR_CFG) begin
                cfg <= (cfg & ~wmask) | (wb_dat_i & wmask);
            end
            if (wb_adr_i == `COL_ADR_PPK) begin
                ppk <= (ppk & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end
        end
    end

    // read data latched with the ack; unmapped offsets read zero
    always_comb begin
        case (wb_adr_i)
            `COL_ADR_CFG: rd_mux = cfg;
            `COL_ADR_PPK: rd_mux = {16'h0000, ppk};
            `COL_ADR_STATUS_A: rd_mux = g_ol[0].status;
            `COL_ADR_STATUS_B: rd_mux = g_ol[1].status;
            `COL_ADR_ENERGY_A: rd_mux = g_ol[0].wh;
            `COL_ADR_ENERGY_B: rd_mux = g_ol[1].wh;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
        end
    end

    assign raw_in[0] = outlet_a_in;
    assign raw_in[1] = outlet_b_in;

    // one independent supervisor per outlet
    for (genvar i = 0; i < 2; i++) begin : g_ol
        col_pkg::col_in_t db;
        col_pkg::col_in_t db_q;
        col_pkg::col_state_t state;
        col_pkg::col_out_t out_q;
        logic start_ev;
        logic stop_ev;
        logic opt_ev;
        logic clr;
        logic magnet;
        logic moving;
        logic [15:0] op_ms;
        logic [17:0] wait_ms;
        logic lock_tmo;
        logic lock_fault;
        logic rcd_fault;
        logic meter_err;
        logic fault_any;
        logic abort;
        logic opt_req;
        logic [7:0] hi_ms;
        logic pulse_ev;
        logic [16:0] acc;
        logic [31:0] wh;
        logic [31:0] status;

        col_debounce #(
            .W($bits(col_pkg::col_in_t))
        ) u_db (
            .clk(clk),
            .arst_n(arst_n),
            .tick(ms_tick),
            .raw(raw_in[i]),
            .stable(db)
        );

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                db_q <= '0;
            end else begin
                db_q <= db;
            end
        end

        // a press is a falling edge of the grounded key, or a command bit
        assign start_ev = (~db.start_key_n & db_q.start_key_n) | cmd[`COL_CMD_START + i];
        assign stop_ev = (~db.stop_key_n & db_q.stop_key_n) | cmd[`COL_CMD_STOP + i];
        assign opt_ev = (~db.opt_key_n & db_q.opt_key_n) | cmd[`COL_CMD_OPT + i];
        assign clr = cmd[`COL_CMD_CLR + i];
        assign magnet = cfg[`COL_CFG_MAGNET + i];
        assign moving = (state == col_pkg::COL_LOCKING) || (state == col_pkg::COL_UNLOCKING);
        assign lock_tmo = (op_ms >= cfg[`COL_CFG_TMO_LSB +: 16]) || (wait_ms >= 18'(BACKUP_WAIT_MS));
        assign fault_any = lock_fault | rcd_fault | meter_err | db.cable_bad;
        assign abort = stop_ev | ~mains_up | db.rcd_trip;

        // travel timer runs while pins move; energy wait timed apart
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                op_ms <= 16'h0000;
                wait_ms <= 18'h00000;
            end else if (!moving) begin
                op_ms <= 16'h0000;
                wait_ms <= 18'h00000;
            end else if (ms_tick) begin
                if (drive_ok) begin
                    op_ms <= op_ms + 16'h0001;
                end else begin
                    wait_ms <= wait_ms + 18'h00001;
                end
            end
        end

        // session sequence
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                state <= col_pkg::COL_IDLE;
            end else begin
                case (state)
                    col_pkg::COL_IDLE: begin
                        if (start_ev) begin
                            state <= col_pkg::COL_ARMED;
                        end
                    end
                    col_pkg::COL_ARMED: begin
                        if (stop_ev) begin
                            state <= col_pkg::COL_IDLE;
                        end else if (db.cable_ok && db.vehicle_ready && !fault_any && mains_up) begin
                            state <= col_pkg::COL_LOCKING;
                        end
                    end
                    col_pkg::COL_LOCKING: begin
                        if (abort || lock_tmo) begin
                            state <= col_pkg::COL_STOPPING;
                        end else if (db.lock_sw && drive_ok) begin
                            state <= col_pkg::COL_CHARGING;
                        end
                    end
                    col_pkg::COL_CHARGING: begin
                        // a lock that lets go mid-session ends the session
                        if (abort || !db.lock_sw || fault_any) begin
                            state <= col_pkg::COL_STOPPING;
                        end
                    end
                    col_pkg::COL_STOPPING: begin
                        // the lock stays shut while the contactor still reports closed
                        if (!db.contactor_fb) begin
                            state <= col_pkg::COL_UNLOCKING;
                        end
                    end
                    col_pkg::COL_UNLOCKING: begin
                        if (!db.lock_sw || lock_tmo) begin
                            state <= col_pkg::COL_IDLE;
                        end
                    end
                    default: state <= col_pkg::COL_IDLE;
                endcase
            end
        end

        // sticky faults; an event in the clear cycle still sets the flag
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                lock_fault <= 1'b0;
                rcd_fault <= 1'b0;
            end else begin
                lock_fault <= (moving & lock_tmo) | (state == col_pkg::COL_CHARGING & ~db.lock_sw)
                    | (lock_fault & ~clr);
                rcd_fault <= db.rcd_trip | (rcd_fault & ~clr);
            end
        end

        // optimised request lives until a stop key press or stop command
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                opt_req <= 1'b0;
            end else begin
                opt_req <= opt_ev | (opt_req & ~stop_ev);
            end
        end

        // meter pulse width in ms, saturating so a stuck-high input cannot wrap
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                hi_ms <= 8'h00;
            end else if (!db.meter) begin
                hi_ms <= 8'h00;
            end else if (ms_tick && hi_ms != 8'hFF) begin
                hi_ms <= hi_ms + 8'h01;
            end
        end

        assign pulse_ev = db_q.meter & ~db.meter & (hi_ms >= 8'(`COL_PULSE_MIN_TICKS))
            & (hi_ms <= 8'(`COL_PULSE_MAX_TICKS));

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meter_err <= 1'b0;
            end else begin
                meter_err <= (db.meter & (hi_ms > 8'(`COL_PULSE_MAX_TICKS))) | (meter_err & ~clr);
            end
        end

        // energy: each pulse adds 1000 Wh-units, whole Wh drained one per cycle
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                acc <= 17'h00000;
                wh <= 32'h00000000;
            end else if (state == col_pkg::COL_ARMED && ppk == 16'h0000) begin
                acc <= 17'h00000;
            end else if (state == col_pkg::COL_LOCKING && op_ms == 16'h0000 && wait_ms == 18'h00000) begin
                acc <= 17'h00000;
                wh <= 32'h00000000;
            end else if (pulse_ev && ppk != 16'h0000) begin
                acc <= acc + `COL_WH_PER_KWH;
            end else if (ppk != 16'h0000 && acc >= {1'b0, ppk}) begin
                acc <= acc - {1'b0, ppk};
                wh <= wh + 32'h00000001;
            end
        end

        // output stage; every port bit from a flip-flop
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                out_q <= '0;
            end else begin
                if (magnet) begin
                    out_q.lock_pos <= drive_ok & ((state == col_pkg::COL_LOCKING)
                        | (state == col_pkg::COL_CHARGING) | (state == col_pkg::COL_STOPPING));
                    out_q.lock_neg <= 1'b0;
                end else begin
                    out_q.lock_pos <= drive_ok & (state == col_pkg::COL_LOCKING) & ~db.lock_sw;
                    out_q.lock_neg <= drive_ok & (state == col_pkg::COL_UNLOCKING) & db.lock_sw
                        & ~db.contactor_fb;
                end
                out_q.contactor_on <= (state == col_pkg::COL_CHARGING) & db.lock_sw & ~abort
                    & ~fault_any;
                out_q.fault_lamp <= fault_any;
                if (state == col_pkg::COL_CHARGING) begin
                    out_q.ready_lamp <= 1'b1;
                end else if (state == col_pkg::COL_ARMED || state == col_pkg::COL_LOCKING
                    || (state == col_pkg::COL_IDLE && db.cable_ok)) begin
                    out_q.ready_lamp <= flash;
                end else begin
                    out_q.ready_lamp <= 1'b0;
                end
                out_q.optimised_lamp <= opt_req;
            end
        end

        assign status = {13'h0000, mains_up, energy_ok, backup_fitted, 3'h0, opt_req, db.cable_bad,
            meter_err, rcd_fault, lock_fault, 1'b0, out_q.contactor_on, db.contactor_fb, db.lock_sw,
            1'b0, state};
    end

    assign outlet_a_out = g_ol[0].out_q;
    assign outlet_b_out = g_ol[1].out_q;

endmodule : col_top

// File: testbench/charge_outlet_lock_and_feedback_bench.sv
// self-checking bench for the two-outlet lock, feedback and panel supervisor
`timescale 1ns/1ps
`include "col_defines.svh"
module charge_outlet_lock_and_feedback_bench;
    localparam int MS = 10;
    // control bits below lock_sw and contactor_fb, then output bits
    localparam int KR = 7, KM = 6, KS = 5, KP = 4, KO = 3, KC = 2, KV = 1;
    localparam int LP = 5, LN = 4, CO = 3, FL = 2, RL = 1, OL = 0;
    logic clk, arst_n, cyc, stb, we, ack, sw_a, fb_a, sw_b, fb_b, mains, bk_fit, bk_ok, stuck_a;
    logic [7:0] adr, ctl_a, ctl_b;
    logic [31:0] wdat, rdat, q;
    col_pkg::col_in_t in_a, in_b;
    col_pkg::col_out_t out_a, out_b;
    int n_mismatch = 0;
    int n_tests = 0;
    assign in_a = {sw_a, fb_a, ctl_a};
    assign in_b = {sw_b, fb_b, ctl_b};
    col_top #(.MS_CYCLES(MS), .BACKUP_WAIT_MS(60)) DUT (.clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .outlet_a_in(in_a), .outlet_b_in(in_b), .mains_ok(mains), .backup_present(bk_fit),
        .backup_energy_ok(bk_ok), .outlet_a_out(out_a), .outlet_b_out(out_b));
    col_station #(.TRAVEL(10 * MS)) u_sta (.clk, .arst_n, .drive(out_a), .magnet(1'b0), .stuck(stuck_a),
        .lock_sw(sw_a), .contactor_fb(fb_a));
    col_station #(.TRAVEL(10 * MS)) u_stb (.clk, .arst_n, .drive(out_b), .magnet(1'b1), .stuck(1'b0),
        .lock_sw(sw_b), .contactor_fb(fb_b));
    // 250 MHz clock
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic ms(input int n);
        repeat (n * MS) @(posedge clk);
    endtask : ms
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic cycle; waits for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        q = rdat;
        chk("bus ack", 1'h1, ack);
        cyc <= 0;
        stb <= 0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm, input logic [31:0] m = '1);
        wb(0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rd
    task automatic flip(input bit b, input int k);
        @(posedge clk);
        if (b) ctl_b[k] <= ~ctl_b[k];
        else ctl_a[k] <= ~ctl_a[k];
    endtask : flip
    task automatic pulse(input bit b, input int k, input int n);
        flip(b, k);
        ms(n);
        flip(b, k);
    endtask : pulse
    // bounded wait for an output bit, sampled after the edge
    task automatic wout(input bit b, input int k, input logic v, input int n, input string nm);
        for (int i = 0; i < n * MS; i++) begin
            @(posedge clk);
            #1;
            if ((b ? out_b[k] : out_a[k]) === v) break;
        end
        chk(nm, v, b ? out_b[k] : out_a[k]);
    endtask : wout
    task automatic t_regs;
        rd(`COL_ADR_CFG, `COL_CFG_RST, "cfg");
        rd(`COL_ADR_PPK, `COL_PPK_RST, "ppk");
        wb(1, `COL_ADR_CFG, 32'h00140002);
        wb(1, `COL_ADR_PPK, 32'h00000002);
        wb(1, 8'h1C, 32'hFFFFFFFF);
        rd(`COL_ADR_CFG, 32'h00140002, "cfg wr");
        rd(8'h1C, 32'h0, "unmapped");
        rd(`COL_ADR_CMD, 32'h0, "cmd");
    endtask : t_regs
    task automatic t_sess_a;
        chk("a ready idle", 1'h0, out_a.ready_lamp);
        pulse(0, KO, 20);
        wout(0, OL, 1, 10, "a opt lamp");
        pulse(0, KS, 20);
        wout(0, RL, 1, 600, "a flash on");
        wout(0, RL, 0, 600, "a flash off");
        chk("a no lock", 1'h0, out_a.lock_pos);
        flip(0, KC);
        flip(0, KV);
        wout(0, LP, 1, 10, "a lock");
        chk("a lock neg", 1'h0, out_a.lock_neg);
        wout(0, CO, 1, 30, "a contactor");
        chk("a switch", 1'h1, sw_a);
        chk("a ready on", 1'h1, out_a.ready_lamp);
        chk("b idle", 32'h0, out_b);
        pulse(0, KM, 20);
        ms(40);
        pulse(0, KM, 100);
        ms(60);
        rd(`COL_ADR_ENERGY_A, 32'h000001F4, "a energy");
        flip(0, KP);
        wout(0, CO, 0, 10, "a contactor off");
        chk("a no unlock", 1'h0, out_a.lock_neg);
        wout(0, LN, 1, 15, "a unlock");
        flip(0, KP);
        wout(0, LN, 0, 30, "a unlock end");
        chk("a opt off", 1'h0, out_a.optimised_lamp);
        pulse(0, KM, 250);
        rd(`COL_ADR_STATUS_A, 32'h00000400, "a meter err", 32'h00000400);
        chk("a fault lamp", 1'h1, out_a.fault_lamp);
        ms(10);
        wb(1, `COL_ADR_CMD, 32'h00000100);
        wout(0, FL, 0, 10, "a fault clear");
    endtask : t_sess_a
    task automatic t_sess_b;
        flip(1, KC);
        flip(1, KV);
        ms(10);
        wb(1, `COL_ADR_CMD, 32'h00000002);
        wout(1, CO, 1, 40, "b contactor");
        chk("b magnet hold", 1'h1, out_b.lock_pos);
        chk("a untouched", 1'h0, out_a.contactor_on);
        flip(1, KR);
        wout(1, CO, 0, 10, "b trip off");
        wout(1, FL, 1, 2, "b trip fault");
        ms(10);
        flip(1, KR);
        wout(1, LP, 0, 30, "b release");
        ms(10);
        wb(1, `COL_ADR_CMD, 32'h00000200);
        wout(1, FL, 0, 10, "b clear");
    endtask : t_sess_b
    task automatic t_tmo;
        stuck_a <= 1;
        wb(1, `COL_ADR_CMD, 32'h00000001);
        wout(0, LP, 1, 10, "a lock try");
        ms(15);
        chk("a still driving", 1'h1, out_a.lock_pos);
        wout(0, LP, 0, 10, "a lock stop");
        chk("a lock fault", 1'h1, out_a.fault_lamp);
        stuck_a <= 0;
        wb(1, `COL_ADR_CMD, 32'h00000100);
        wout(0, FL, 0, 10, "a clear 2");
    endtask : t_tmo
    task automatic t_mains;
        bk_fit <= 1;
        ms(10);
        rd(`COL_ADR_STATUS_A, 32'h00010000, "backup seen", 32'h00010000);
        wb(1, `COL_ADR_CMD, 32'h00000001);
        wout(0, CO, 1, 40, "a charge 2");
        bk_ok <= 0;
        mains <= 0;
        wout(0, CO, 0, 10, "mains cut");
        ms(15);
        chk("backup wait", 1'h0, out_a.lock_neg);
        bk_ok <= 1;
        wout(0, LN, 1, 15, "mains unlock");
        mains <= 1;
        wout(0, LN, 0, 30, "mains unlock end");
    endtask : t_mains
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // keys idle high, no cable, mains present
    initial begin
        {arst_n, cyc, stb, we, adr, wdat, bk_fit, stuck_a} = '0;
        {mains, bk_ok} = 2'h3;
        ctl_a = 8'h38;
        ctl_b = 8'h38;
        repeat (3) @(posedge clk);
        arst_n <= 1;
        t_regs();
        ms(10);
        t_sess_a();
        t_sess_b();
        t_tmo();
        t_mains();
        summarize();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] watchdog expected done seen hang");
        summarize();
    end
endmodule : charge_outlet_lock_and_feedback_bench

// File: testbench/col_station.sv
// station model: lock actuator with end switch, contactor with aux contact
`timescale 1ns/1ps
module col_station #(
    parameter int TRAVEL = 100
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire col_pkg::col_out_t drive,
    input wire logic magnet,
    input wire logic stuck,
    output logic lock_sw,
    output logic contactor_fb
);
    int pos;
    int fb_t;
    // pins move one step a cycle while driven; a magnet lock springs back once released
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos <= 0;
        end else if (!stuck && drive.lock_pos && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (!stuck && (drive.lock_neg || (magnet && !drive.lock_pos)) && pos > 0) begin
            pos <= pos - 1;
        end
    end
    // end switch closes only at full extension
    assign lock_sw = (pos == TRAVEL);
    // aux contact lags the coil both ways
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) fb_t <= 0;
        else fb_t <= drive.contactor_on ? fb_t + int'(fb_t < 60) : fb_t - int'(fb_t > 0);
    end
    assign contactor_fb = (fb_t >= 30);
endmodule : col_station

// File: testbench/col_top_chk.sv
// port assertions for the outlet supervisor, bound into col_top
`timescale 1ns/1ps
module col_top_chk #(
    parameter int unsigned MS_CYCLES = 10
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire col_pkg::col_in_t outlet_a_in,
    input wire col_pkg::col_in_t outlet_b_in,
    input wire logic mains_ok,
    input wire logic backup_present,
    input wire logic backup_energy_ok,
    input wire col_pkg::col_out_t outlet_a_out,
    input wire col_pkg::col_out_t outlet_b_out
);
    // settle time: debounce plus a few state steps
    localparam int LIM = 8 * MS_CYCLES;
    col_pkg::col_out_t oa;
    col_pkg::col_out_t ob;
    int fb_n, rcd_n, off_n, bk_n;
    assign oa = outlet_a_out;
    assign ob = outlet_b_out;
    // cycles held: contact a closed, trip b active, mains lost, backup short of energy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {fb_n, rcd_n, off_n, bk_n} <= '0;
        end else begin
            fb_n <= outlet_a_in.contactor_fb ? fb_n + int'(fb_n < LIM) : 0;
            rcd_n <= outlet_b_in.rcd_trip ? rcd_n + int'(rcd_n < LIM) : 0;
            off_n <= !mains_ok ? off_n + int'(off_n < LIM) : 0;
            bk_n <= (backup_present && !backup_energy_ok) ? bk_n + int'(bk_n < LIM) : 0;
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    bus_answer_a: assert property (bus_req |=> ack_pulse)
        else $error("bus request not answered by a single ack");
    drive_exclusive_a: assert property (!(oa.lock_pos && oa.lock_neg) && !(ob.lock_pos && ob.lock_neg))
        else $error("lock driven both ways");
    unlock_after_off_a: assert property (oa.lock_neg |-> !oa.contactor_on)
        else $error("unlock while supply on");
    unlock_blocked_a: assert property (fb_n >= LIM |-> !oa.lock_neg)
        else $error("unlock while contactor closed");
    mains_cut_a: assert property (off_n >= LIM |-> !oa.contactor_on && !ob.contactor_on)
        else $error("supply on without mains");
    rcd_fault_a: assert property (rcd_n >= LIM |-> !ob.contactor_on && ob.fault_lamp)
        else $error("trip not handled");
    backup_hold_a: assert property (bk_n >= LIM |-> !oa.lock_pos && !oa.lock_neg)
        else $error("lock moved without stored energy");
    lamp_steady_a: assert property (oa.contactor_on |-> oa.ready_lamp)
        else $error("ready lamp not steady while charging");
    lock_first_a: assert property ($rose(oa.contactor_on) |-> outlet_a_in.lock_sw)
        else $error("supply on before lock confirmed");
endmodule : col_top_chk

bind col_top col_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .outlet_a_in, .outlet_b_in, .mains_ok, .backup_present, .backup_energy_ok, .outlet_a_out, .outlet_b_out);
